// >>> hdl/ofm_regs.vh
// Register map, function codes and timing constants of the output terminal mux
`ifndef OFM_REGS_VH
`define OFM_REGS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define OFM_ADR_TYPE   8'h00
`define OFM_ADR_HOST   8'h04
`define OFM_ADR_FSEL0  8'h08
`define OFM_ADR_FSEL5  8'h1c
`define OFM_ADR_PW0    8'h20
`define OFM_ADR_PW3    8'h2c
`define OFM_ADR_ZST    8'h30
`define OFM_ADR_OCL    8'h34
`define OFM_ADR_OCD    8'h38
`define OFM_ADR_STAT   8'h3c

// ****************************************************************
// Field layouts and reset values
// ****************************************************************
`define OFM_FSEL_BASE  3'h2
`define OFM_HOST_MASK  8'h6f
`define OFM_TYPE_RST   4'h0
`define OFM_HOST_RST   8'h00
`define OFM_FSEL_RST   7'h00
`define OFM_PW_RST     15'h00fa
`define OFM_PW_MIN     15'h0001
`define OFM_PW_MAX     15'h7530
`define OFM_WORD_RST   16'h0000

// ****************************************************************
// Terminal function codes
// ****************************************************************
`define OFM_FN_OFFLOAD 7'h26
`define OFM_FN_ZERO    7'h27
`define OFM_FN_CUR     7'h28
`define OFM_FN_TRQ     7'h29
`define OFM_FN_SPD     7'h2a
`define OFM_FN_HOST    7'h2f
`define OFM_FN_BRAKE   7'h43
`define OFM_FN_CUTOFF  7'h44
`define OFM_FN_LOWA    7'h45
`define OFM_FN_LOWB    7'h46
`define OFM_FN_LOWAJ   7'h47
`define OFM_FN_LOWBJ   7'h48
`define OFM_FN_OVC     7'h49

// ****************************************************************
// Timing: clock rate, tick period, level-mode self-clear of 0.1 s
// ****************************************************************
`define OFM_CLK_MHZ    20
`define OFM_TICK_US    1000
`define OFM_SELFCLR_MS 15'h0064

`endif

// >>> hdl/ofm_term.v
// One output terminal: level follower or timed single pulse
`timescale 1ns/1ns
`include "ofm_regs.vh"
module ofm_term (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Timing base
	input  wire        tick_i,
	// Function state and shaping
	input  wire        cond_i,
	input  wire        timed_i,
	input  wire [14:0] width_i,
	input  wire        mask_i,
	// Terminal drive
	output wire        out_o
);

	reg        cond_d_r;
	reg [14:0] cnt_r;
	reg        out_r;
	wire       rise;
	wire       last;

	// Only a rising edge of the function starts a pulse
	assign rise  = cond_i & ~cond_d_r;
	assign last  = tick_i & (cnt_r == `OFM_PW_MIN);
	assign out_o = out_r;

	// ****************************************************************
	// Shaping
	// ****************************************************************
	// Level path follows the function; timed path counts ms ticks down
	always @(posedge clk_i) begin
		if (rst_i) begin
			cond_d_r <= 1'b0;
			cnt_r    <= 15'h0000;
			out_r    <= 1'b0;
		end else begin
			cond_d_r <= cond_i;
			if (!timed_i) begin
				cnt_r <= 15'h0000;
				out_r <= cond_i & ~mask_i;
			end else begin
				if (rise)
					cnt_r <= width_i;
				else if (tick_i && cnt_r != 15'h0000)
					cnt_r <= cnt_r - 15'h0001;
				out_r <= (rise | ((cnt_r != 15'h0000) & ~last)) & ~mask_i;
			end
		end
	end

endmodule // ofm_term

// >>> hdl/ofm_mux.v
// Multi-function digital output terminal mux with Wishbone registers
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "ofm_regs.vh"
module ofm_mux #(
	parameter TICK_CYCLES = `OFM_CLK_MHZ * `OFM_TICK_US
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output wire        wb_ack_o,
	// Drive status from the control core
	input  wire [15:0] output_frequency_monitor_i,
	input  wire [15:0] motor_current_i,
	input  wire        current_reached_i,
	input  wire        torque_reached_i,
	input  wire        speed_reached_i,
	input  wire        off_load_i,
	input  wire        brake_engaged_i,
	input  wire        material_cutoff_i,
	input  wire        freq_detect_window_a_low_i,
	input  wire        freq_detect_window_b_low_i,
	input  wire        jog_active_i,
	// Terminal drives
	output wire        open_collector_out_a_o,
	output wire        open_collector_out_b_o,
	output wire        relay_out_a_o,
	output wire        relay_out_b_o,
	output wire        relay_out_c_o,
	output wire        relay_out_d_o
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	reg  [3:0]  output_type_select_r;
	reg  [7:0]  host_output_bits_r;
	reg  [6:0]  fsel_r [0:5];
	reg  [14:0] pw_r [0:3];
	reg  [15:0] zero_speed_threshold_r;
	reg  [15:0] overcurrent_detect_level_r;
	reg  [15:0] overcurrent_detect_duration_r;
	reg  [15:0] oc_cnt_r;
	reg  [14:0] tick_cnt_r;
	reg         tick_r;
	reg         ack_r;
	reg  [31:0] dat_r;
	reg  [31:0] rd_nxt;
	wire [31:0] wr_val;
	wire        req;
	wire        wr;
	wire [2:0]  fidx;
	wire [1:0]  pidx;
	wire        oc_above;
	wire        oc_timed;
	wire [5:0]  term;

	// Tick counter wraps at the last cycle of each period, cut to the counter width
	localparam integer TICK_SPAN = TICK_CYCLES - 1;
	localparam [14:0]  TICK_LAST = TICK_SPAN[14:0];

	assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr       = req & wb_we_i;
	assign fidx     = wb_adr_i[4:2] - `OFM_FSEL_BASE;
	assign pidx     = wb_adr_i[3:2];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// Byte-lane merge of write data into the current register value
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				merge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
		end
	endfunction

	// Keep the pulse width inside its legal range
	function [14:0] clamp;
		input [15:0] v;
		begin
			if (v < {1'b0, `OFM_PW_MIN})
				clamp = `OFM_PW_MIN;
			else if (v > {1'b0, `OFM_PW_MAX})
				clamp = `OFM_PW_MAX;
			else
				clamp = v[14:0];
		end
	endfunction

	assign wr_val = merge(rd_nxt, wb_dat_i, wb_sel_i);

	// ****************************************************************
	// Read decode
	// ****************************************************************
	// Unmapped addresses read as zero
	always @* begin
		rd_nxt = 32'h0000_0000;
		if (wb_adr_i == `OFM_ADR_TYPE)
			rd_nxt[3:0] = output_type_select_r;
		else if (wb_adr_i == `OFM_ADR_HOST)
			rd_nxt[7:0] = host_output_bits_r;
		else if (wb_adr_i >= `OFM_ADR_FSEL0 && wb_adr_i <= `OFM_ADR_FSEL5
			&& wb_adr_i[1:0] == 2'h0)
			rd_nxt[6:0] = fsel_r[fidx];
		else if (wb_adr_i >= `OFM_ADR_PW0 && wb_adr_i <= `OFM_ADR_PW3
			&& wb_adr_i[1:0] == 2'h0)
			rd_nxt[14:0] = pw_r[pidx];
		else if (wb_adr_i == `OFM_ADR_ZST)
			rd_nxt[15:0] = zero_speed_threshold_r;
		else if (wb_adr_i == `OFM_ADR_OCL)
			rd_nxt[15:0] = overcurrent_detect_level_r;
		else if (wb_adr_i == `OFM_ADR_OCD)
			rd_nxt[15:0] = overcurrent_detect_duration_r;
		else if (wb_adr_i == `OFM_ADR_STAT)
			rd_nxt[6:0] = {oc_timed, term};
	end

	// ****************************************************************
	// Bus handshake and register writes
	// ****************************************************************
	// Ack one cycle after the request, dropped the cycle after
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_r                         <= 1'b0;
			dat_r                         <= 32'h0000_0000;
			output_type_select_r          <= `OFM_TYPE_RST;
			host_output_bits_r            <= `OFM_HOST_RST;
			zero_speed_threshold_r        <= `OFM_WORD_RST;
			overcurrent_detect_level_r    <= `OFM_WORD_RST;
			overcurrent_detect_duration_r <= `OFM_WORD_RST;
		end else begin
			ack_r <= req;
			if (req)
				dat_r <= rd_nxt;
			if (wr) begin
				if (wb_adr_i == `OFM_ADR_TYPE)
					output_type_select_r <= wr_val[3:0];
				else if (wb_adr_i == `OFM_ADR_HOST)
					host_output_bits_r <= wr_val[7:0] & `OFM_HOST_MASK;
				else if (wb_adr_i == `OFM_ADR_ZST)
					zero_speed_threshold_r <= wr_val[15:0];
				else if (wb_adr_i == `OFM_ADR_OCL)
					overcurrent_detect_level_r <= wr_val[15:0];
				else if (wb_adr_i == `OFM_ADR_OCD)
					overcurrent_detect_duration_r <= wr_val[15:0];
			end
		end
	end

	// Function select and pulse width tables
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_fsel
			always @(posedge clk_i) begin
				if (rst_i)
					fsel_r[g] <= `OFM_FSEL_RST;
				else if (wr && wb_adr_i == `OFM_ADR_FSEL0 + g * 4)
					fsel_r[g] <= wr_val[6:0];
			end
		end
		for (g = 0; g < 4; g = g + 1) begin : g_pw
			always @(posedge clk_i) begin
				if (rst_i)
					pw_r[g] <= `OFM_PW_RST;
				else if (wr && wb_adr_i == `OFM_ADR_PW0 + g * 4)
					pw_r[g] <= clamp(wr_val[15:0]);
			end
		end
	endgenerate

	// ****************************************************************
	// Millisecond tick
	// ****************************************************************
	// One-cycle tick every TICK_CYCLES clocks
	always @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_r <= 15'h0000;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == TICK_LAST) begin
			tick_cnt_r <= 15'h0000;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 15'h0001;
			tick_r     <= 1'b0;
		end
	end

	// ****************************************************************
	// Overcurrent duration timer
	// ****************************************************************
	// Restarts whenever current drops to the level or below
	assign oc_above = motor_current_i > overcurrent_detect_level_r;
	assign oc_timed = oc_above && oc_cnt_r >= overcurrent_detect_duration_r;

	always @(posedge clk_i) begin
		if (rst_i)
			oc_cnt_r <= 16'h0000;
		else if (!oc_above)
			oc_cnt_r <= 16'h0000;
		else if (tick_r && oc_cnt_r < overcurrent_detect_duration_r)
			oc_cnt_r <= oc_cnt_r + 16'h0001;
	end

	// ****************************************************************
	// Per-terminal function mux and shaping
	// ****************************************************************
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_term
			localparam HB = (g < 4) ? g : g + 1;
			reg         cond;
			reg         selfclr;
			reg         jogmask;
			wire        pmode;
			wire [14:0] pw;
			wire [14:0] width;

			// Relays c and d have no pulse type bit and no width
			if (g < 4) begin : g_pm
				assign pmode = output_type_select_r[g];
				assign pw    = pw_r[g];
			end else begin : g_lv
				assign pmode = 1'b0;
				assign pw    = `OFM_PW_RST;
			end

			assign width = pmode ? pw : `OFM_SELFCLR_MS;

			// Select the drive condition from the function code
			always @* begin
				cond    = 1'b0;
				selfclr = 1'b0;
				jogmask = 1'b0;
				case (fsel_r[g])
				`OFM_FN_OFFLOAD: cond = off_load_i;
				`OFM_FN_ZERO: cond = output_frequency_monitor_i
					<= zero_speed_threshold_r;
				`OFM_FN_CUR: cond = current_reached_i;
				`OFM_FN_TRQ: cond = torque_reached_i;
				`OFM_FN_SPD: cond = speed_reached_i;
				`OFM_FN_HOST: cond = host_output_bits_r[HB];
				`OFM_FN_BRAKE: cond = brake_engaged_i;
				`OFM_FN_CUTOFF: cond = material_cutoff_i;
				`OFM_FN_LOWA: begin
					cond    = freq_detect_window_a_low_i;
					selfclr = 1'b1;
				end
				`OFM_FN_LOWB: begin
					cond    = freq_detect_window_b_low_i;
					selfclr = 1'b1;
				end
				`OFM_FN_LOWAJ: begin
					cond    = freq_detect_window_a_low_i & ~jog_active_i;
					selfclr = 1'b1;
					jogmask = jog_active_i;
				end
				`OFM_FN_LOWBJ: begin
					cond    = freq_detect_window_b_low_i & ~jog_active_i;
					selfclr = 1'b1;
					jogmask = jog_active_i;
				end
				`OFM_FN_OVC: cond = oc_timed;
				default: cond = 1'b0;
				endcase
			end

			ofm_term u_term (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.tick_i  (tick_r),
				.cond_i  (cond),
				.timed_i (pmode | selfclr),
				.width_i (width),
				.mask_i  (jogmask),
				.out_o   (term[g])
			);
		end
	endgenerate

	// ****************************************************************
	// Terminal drives
	// ****************************************************************
	// High turns the switch on or energises the coil
	assign open_collector_out_a_o = term[0];
	assign open_collector_out_b_o = term[1];
	assign relay_out_a_o          = term[2];
	assign relay_out_b_o          = term[3];
	assign relay_out_c_o          = term[4];
	assign relay_out_d_o          = term[5];

endmodule // ofm_mux

// >>> testbench/ofm_mux_monitor.sv
// Port checker for the output terminal mux
`timescale 1ns/1ns
module ofm_mux_monitor #(
	parameter TICK_CYCLES = 20000
) (
	// Clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// Wishbone slave
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_we_i,
	input wire [3:0]  wb_sel_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_ack_o,
	// Status and first terminal
	input wire        current_reached_i,
	input wire        jog_active_i,
	input wire        open_collector_out_a_o
);
	reg  [6:0]  fsel_r;
	reg         typ_r;
	reg  [14:0] pw_r;
	reg  [31:0] hi_r;
	wire        wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i == 4'hf;
	wire [14:0] pw_nxt = (wb_dat_i == 32'h0) ? 15'h0001 :
		(wb_dat_i > 32'h7530) ? 15'h7530 : wb_dat_i[14:0];
	// Shadow of terminal a settings and length of its current high run
	always @(posedge clk_i) begin
		hi_r <= open_collector_out_a_o ? hi_r + 32'h1 : 32'h0;
		if (rst_i) begin
			fsel_r <= 7'h00;
			typ_r <= 1'b0;
			pw_r <= 15'h00fa;
		end else if (wr) begin
			if (wb_adr_i == 8'h08) fsel_r <= wb_dat_i[6:0];
			if (wb_adr_i == 8'h00) typ_r <= wb_dat_i[0];
			if (wb_adr_i == 8'h20) pw_r <= pw_nxt;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_jog; jog_active_i && (fsel_r == 7'h47 || fsel_r == 7'h48); endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	a_ack_answer: assert property (s_take |=> wb_ack_o) else $error("request not acked");
	a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_dat_hold: assert property (!$past(wb_cyc_i && wb_stb_i && !wb_ack_o) |-> $stable(wb_dat_o))
		else $error("read data changed while idle");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o &&
		!open_collector_out_a_o && wb_dat_o == 32'h0) else $error("reset state wrong");
	a_level_track: assert property (!typ_r && fsel_r == 7'h28 |=>
		open_collector_out_a_o == $past(current_reached_i)) else $error("level lost");
	a_pulse_start: assert property (typ_r && fsel_r == 7'h28 && $rose(current_reached_i)
		|=> open_collector_out_a_o) else $error("pulse missing");
	a_pulse_len: assert property (typ_r && open_collector_out_a_o |->
		hi_r <= pw_r * TICK_CYCLES + 2) else $error("pulse too long");
	a_jog_mask: assert property (s_jog ##1 s_jog |-> !open_collector_out_a_o)
		else $error("output during jog");
	a_reserved_idle: assert property (fsel_r == 7'h00 && $past(fsel_r) == 7'h00 |->
		!open_collector_out_a_o) else $error("reserved code active");
endmodule // ofm_mux_monitor

bind ofm_mux ofm_mux_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .current_reached_i(current_reached_i),
	.jog_active_i(jog_active_i), .open_collector_out_a_o(open_collector_out_a_o));

// >>> testbench/ofm_load.sv
// Machinery on a terminal: counts switch closures
`timescale 1ns/1ns
module ofm_load (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Terminal switch and closure count
	input  wire       sw_i,
	output reg  [7:0] closures_o
);
	reg sw_r;
	// Count each off-to-on change of the switch
	always @(posedge clk_i) begin
		sw_r <= sw_i;
		if (rst_i)
			closures_o <= 8'h00;
		else if (sw_i && !sw_r)
			closures_o <= closures_o + 8'h01;
	end
endmodule // ofm_load

// >>> testbench/ofm_mux_tb.sv
// Register-level testbench for the output terminal mux
`timescale 1ns/1ns
`include "ofm_regs.vh"
module ofm_mux_tb;
	localparam TK = 8;
	reg        clk_i = 1'b0;
	reg        rst_i = 1'b1;
	reg [7:0]  adr = 8'h00;
	reg [31:0] dat = 32'h0;
	reg        we = 1'b0, cyc = 1'b0, stb = 1'b0;
	reg [3:0]  sel = 4'h0;
	reg [15:0] freq = 16'h0000, mcur = 16'h0000;
	reg [5:0]  st = 6'h00;
	reg        wla = 1'b0, wlb = 1'b0, jog = 1'b0;
	reg [31:0] rdv;
	reg [7:0]  c0;
	wire [31:0] q;
	wire        ack;
	wire [5:0]  o;
	wire [7:0]  nclose;
	logic [6:0] codes [6] = '{`OFM_FN_OFFLOAD, `OFM_FN_CUR, `OFM_FN_TRQ, `OFM_FN_SPD,
		`OFM_FN_BRAKE, `OFM_FN_CUTOFF};
	int miscompares = 0, checks = 0, n, i;
	ofm_mux #(.TICK_CYCLES(TK)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(q),
		.wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.output_frequency_monitor_i(freq), .motor_current_i(mcur),
		.current_reached_i(st[1]), .torque_reached_i(st[2]), .speed_reached_i(st[3]),
		.off_load_i(st[0]), .brake_engaged_i(st[4]), .material_cutoff_i(st[5]),
		.freq_detect_window_a_low_i(wla), .freq_detect_window_b_low_i(wlb),
		.jog_active_i(jog), .open_collector_out_a_o(o[0]), .open_collector_out_b_o(o[1]),
		.relay_out_a_o(o[2]), .relay_out_b_o(o[3]), .relay_out_c_o(o[4]), .relay_out_d_o(o[5]));
	ofm_load u_load (.clk_i(clk_i), .rst_i(rst_i), .sw_i(o[0]), .closures_o(nclose));
	// Clock of 50 ns
	initial forever #25 clk_i = ~clk_i;
	task report_and_stop;
		if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task wbx(input w, input [7:0] a, input [31:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		k = 0;
		do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 40);
		chk(k < 40, 1);
		rdv = q;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input [7:0] a, input [31:0] d); wbx(1'b1, a, d); endtask
	task rd(input [7:0] a, input [31:0] e); wbx(1'b0, a, 32'h0); chk(rdv, e); endtask
	task step(input int c); repeat (c) @(posedge clk_i); endtask
	// Count cycles while terminal a stays at the given level
	task run(input v);
		n = 0;
		while (o[0] === v && n < 3000) begin @(posedge clk_i); n++; end
	endtask
	// Main sequence
	initial begin
		step(12);
		rst_i <= 1'b0;
		rd(`OFM_ADR_TYPE, 32'h0);
		rd(`OFM_ADR_PW0, 32'h00fa);
		rd(8'h40, 32'h0);
		chk(o, 6'h00);
		wr(`OFM_ADR_PW0, 32'h0);
		rd(`OFM_ADR_PW0, 32'h0001);
		wr(`OFM_ADR_PW0, 32'h7fff);
		rd(`OFM_ADR_PW0, 32'h7530);
		wr(`OFM_ADR_HOST, 32'hff);
		rd(`OFM_ADR_HOST, 32'h6f);
		for (i = 0; i < 6; i++) begin
			wr(8'(`OFM_ADR_FSEL0 + 4 * i), `OFM_FN_HOST);
		end
		step(2);
		chk(o, 6'h3f);
		rd(`OFM_ADR_STAT, 32'h3f);
		wr(`OFM_ADR_HOST, 32'h22);
		step(2);
		chk(o, 6'h12);
		wr(`OFM_ADR_HOST, 32'h0);
		step(2);
		chk(o, 6'h00);
		for (i = 0; i < 6; i++) begin
			wr(`OFM_ADR_FSEL0, codes[i]);
			wr(8'h10, codes[i]);
			st <= 6'h01 << i;
			step(2);
			chk({o[2], o[0]}, 2'b11);
			st <= 6'h00;
			step(2);
			chk({o[2], o[0]}, 2'b00);
		end
		wr(`OFM_ADR_ZST, 32'h64);
		wr(`OFM_ADR_FSEL0, `OFM_FN_ZERO);
		freq <= 16'h0064;
		step(2);
		chk(o[0], 1'b1);
		freq <= 16'h0065;
		step(2);
		chk(o[0], 1'b0);
		wr(`OFM_ADR_FSEL0, 32'h2d);
		st <= 6'h3f;
		step(2);
		chk(o[0], 1'b0);
		st <= 6'h00;
		wr(`OFM_ADR_PW0, 32'h2);
		wr(8'h28, 32'h2);
		wr(`OFM_ADR_FSEL0, `OFM_FN_CUR);
		wr(8'h10, `OFM_FN_CUR);
		wr(`OFM_ADR_TYPE, 32'h5);
		rd(`OFM_ADR_TYPE, 32'h5);
		step(3);
		chk(o[0], 1'b0);
		c0 = nclose;
		st <= 6'h02;
		run(0);
		chk(n <= 3, 1);
		chk(o[2], 1'b1);
		run(1);
		chk(n >= TK && n <= 2 * TK + 2, 1);
		step(20);
		chk({o[0], nclose}, {1'b0, c0 + 8'h01});
		chk(o[2], 1'b0);
		st <= 6'h00;
		wr(`OFM_ADR_TYPE, 32'h0);
		for (i = 0; i < 2; i++) begin
			wr(`OFM_ADR_FSEL0, `OFM_FN_LOWA + i);
			{wlb, wla} <= 2'b01 << i;
			run(0);
			run(1);
			chk(n >= 99 * TK && n <= 100 * TK + 2, 1);
			{wlb, wla} <= 2'b00;
		end
		wr(`OFM_ADR_FSEL0, `OFM_FN_LOWAJ);
		jog <= 1'b1;
		step(2);
		wla <= 1'b1;
		step(20);
		chk(o[0], 1'b0);
		wla <= 1'b0;
		jog <= 1'b0;
		step(2);
		wla <= 1'b1;
		run(0);
		chk(n < 5, 1);
		run(1);
		wla <= 1'b0;
		wr(`OFM_ADR_OCL, 32'ha);
		wr(`OFM_ADR_OCD, 32'h3);
		wr(`OFM_ADR_FSEL0, `OFM_FN_OVC);
		mcur <= 16'h000a;
		step(40);
		chk(o[0], 1'b0);
		mcur <= 16'h000b;
		run(0);
		chk(n >= 2 * TK && n <= 3 * TK + 3, 1);
		rd(`OFM_ADR_STAT, 32'h41);
		mcur <= 16'h0005;
		step(3);
		chk(o[0], 1'b0);
		report_and_stop;
	end
	// Watchdog: fails the test if it is still running after 20000 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		report_and_stop;
	end
endmodule // ofm_mux_tb
